// ==== hdl/lsc_device.sv ====
// light sensor command port: two-wire slave, command decode, integration selector
// =====================================================================
// Functional notes
// - result is 16-bit count, two readable bytes
// - answer only at address 0x39
// - works at 100k and 400k bit rates
// - master sends address msb first, then direction
// - ack valid address on ninth clock
// - write byte msb first, acked after eight
// - direction high requests a read
// - read returns eight bits msb first
// - master nacks the read byte, then stops
// - no repeated start; stop closes each transfer
// - master ends every transaction with stop
// - exactly one data byte per transfer
// - selector 000/001/010 gives 400/200/100 ms
// - 011 test, 100 simulation, 101-111 reserved
// - command 0x00 starts a conversion
// - command 0x03 completes the conversion
// - command 0x43 stages the low byte
// - command 0x83 stages the high byte
// - command 0x1D clears selector bit 0
// - 0x88 sets bit 1, 0x90 bit 2
// - command 0x18 restores selector to 001
// - master orders start, complete, stage, read
//
// The address-and-strobe port and the register addresses are this design's own decisions.
module lsc_device
	import lsc_pkg::*;
#(
	parameter int COUNT_W = LSC_COUNT_W
) (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	lsc_if.device bus,
	input wire logic [COUNT_W-1:0] adc_count_in,
	output logic [2:0] integration_time_select_out,
	output logic conversion_active_out,
	output logic [31:0] integration_us_out,
	output logic result_valid_out
);
	typedef enum logic [2:0] {LSC_S_IDLE, LSC_S_ADDR, LSC_S_ADDR_ACK, LSC_S_WDATA,
		LSC_S_WACK, LSC_S_RDATA, LSC_S_RACK, LSC_S_IGNORE} lsc_dev_state_t;

	// =================================================================
	// pin synchronisers and edge detection
	logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
	logic scl_prev_q, scl_prev_d, sda_prev_q, sda_prev_d;
	logic scl_rise, scl_fall, start_det, stop_det, scl_s, sda_s;

	always_comb begin
		scl_sync_d = {scl_sync_q[0], bus.scl};
		sda_sync_d = {sda_sync_q[0], bus.sda};
		scl_prev_d = scl_sync_q[1];
		sda_prev_d = sda_sync_q[1];
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			scl_sync_q <= LSC_SYNC_RESET;
			sda_sync_q <= LSC_SYNC_RESET;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
		end
	end

	// core clock oversamples both bus rates by at least 15x
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign start_det = scl_s && scl_prev_q && !sda_s && sda_prev_q;
	assign stop_det = scl_s && scl_prev_q && sda_s && !sda_prev_q;

	// =================================================================
	// protocol engine and command state
	lsc_dev_state_t state_q, state_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic sda_oe_q, sda_oe_d;
	logic [2:0] it_q, it_d;
	logic hi_sel_q, hi_sel_d;
	logic conv_q, conv_d;
	logic valid_q, valid_d;
	logic [COUNT_W-1:0] result_q, result_d;
	logic [7:0] staged;

	// the count is snapped at completion so the two reads form one sample
	assign staged = hi_sel_q ? result_q[15:8] : result_q[7:0];

	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		shift_d = shift_q;
		sda_oe_d = sda_oe_q;
		it_d = it_q;
		hi_sel_d = hi_sel_q;
		conv_d = conv_q;
		valid_d = valid_q;
		result_d = result_q;
		if (stop_det) begin
			state_d = LSC_S_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_det) begin
			// a start mid-transfer is not a repeated start we honour: restart clean
			state_d = LSC_S_ADDR;
			bit_d = 4'h0;
			sda_oe_d = 1'b0;
		end else begin
			case (state_q)
				LSC_S_ADDR: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_s};
						bit_d = bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						if (shift_q[7:1] == LSC_SLAVE_ADDR) begin
							sda_oe_d = 1'b1;
							state_d = LSC_S_ADDR_ACK;
						end else begin
							state_d = LSC_S_IGNORE;
						end
					end
				end
				LSC_S_ADDR_ACK: begin
					if (scl_fall) begin
						bit_d = 4'h0;
						if (shift_q[0]) begin
							state_d = LSC_S_RDATA;
							shift_d = staged;
							sda_oe_d = !staged[7];
						end else begin
							state_d = LSC_S_WDATA;
							sda_oe_d = 1'b0;
						end
					end
				end
				LSC_S_WDATA: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_s};
						bit_d = bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						sda_oe_d = 1'b1;
						state_d = LSC_S_WACK;
						if (shift_q == LSC_CMD_START) begin
							conv_d = 1'b1;
							valid_d = 1'b0;
						end else if (shift_q == LSC_CMD_COMPLETE) begin
							conv_d = 1'b0;
							valid_d = 1'b1;
							result_d = adc_count_in;
						end else if (shift_q == LSC_CMD_STAGE_LO) begin
							hi_sel_d = 1'b0;
						end else if (shift_q == LSC_CMD_STAGE_HI) begin
							hi_sel_d = 1'b1;
						end else if (shift_q == LSC_CMD_CLR_IT0) begin
							it_d = {it_q[2:1], 1'b0};
						end else if (shift_q == LSC_CMD_SET_IT1) begin
							it_d = {it_q[2], 1'b1, it_q[0]};
						end else if (shift_q == LSC_CMD_SET_IT2) begin
							it_d = {1'b1, it_q[1:0]};
						end else if (shift_q == LSC_CMD_IT_DEFAULT) begin
							it_d = LSC_IT_RESET;
						end
						// any other byte is acked and has no effect
					end
				end
				LSC_S_WACK: begin
					if (scl_fall) begin
						sda_oe_d = 1'b0;
						state_d = LSC_S_IGNORE;
					end
				end
				LSC_S_RDATA: begin
					if (scl_fall) begin
						bit_d = bit_q + 4'h1;
						if (bit_q == 4'h7) begin
							sda_oe_d = 1'b0;
							state_d = LSC_S_RACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							sda_oe_d = !shift_q[6];
						end
					end
				end
				LSC_S_RACK: begin
					// single byte only: the master's ack bit is not acted on
					if (scl_fall) begin
						state_d = LSC_S_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			state_q <= LSC_S_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			sda_oe_q <= 1'b0;
			it_q <= LSC_IT_RESET;
			hi_sel_q <= 1'b0;
			conv_q <= 1'b0;
			valid_q <= 1'b0;
			result_q <= '0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			sda_oe_q <= sda_oe_d;
			it_q <= it_d;
			hi_sel_q <= hi_sel_d;
			conv_q <= conv_d;
			valid_q <= valid_d;
			result_q <= result_d;
		end
	end

	// =================================================================
	// integration time lookup
	function automatic logic [31:0] lsc_it_us(input logic [2:0] sel);
		case (sel)
			3'h0: lsc_it_us = 32'(LSC_IT_US_000);
			3'h1: lsc_it_us = 32'(LSC_IT_US_001);
			3'h2: lsc_it_us = 32'(LSC_IT_US_010);
			3'h3: lsc_it_us = 32'(LSC_IT_US_011);
			3'h4: lsc_it_us = 32'(LSC_IT_US_100);
			default: lsc_it_us = 32'h0; // reserved codes
		endcase
	endfunction : lsc_it_us

	assign bus.sda_out_s = 1'b0;
	assign bus.sda_oe_s = sda_oe_q;
	assign integration_time_select_out = it_q;
	assign conversion_active_out = conv_q;
	assign result_valid_out = valid_q;
	assign integration_us_out = lsc_it_us(it_q);
endmodule : lsc_device

// ==== hdl/lsc_master.sv ====
// bus master for the light sensor command port, driven from a register port
module lsc_master
	import lsc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	lsc_if.master bus,
	input wire logic [1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out
);
	typedef enum logic [2:0] {LSC_M_IDLE, LSC_M_START, LSC_M_BIT, LSC_M_STOP,
		LSC_M_DONE} lsc_mst_state_t;

	// =================================================================
	// state
	lsc_mst_state_t state_q, state_d;
	logic [6:0] addr_q, addr_d;
	logic rd_q, rd_d, fast_q, fast_d;
	logic [7:0] tx_q, tx_d, rx_q, rx_d;
	logic nack_q, nack_d, done_q, done_d;
	logic [17:0] frame_q, frame_d;
	logic [4:0] idx_q, idx_d;
	logic [1:0] phase_q, phase_d;
	logic [7:0] div_q, div_d;
	logic scl_q, scl_d, sda_q, sda_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] sda_sync_q;
	logic tick, sda_s;

	assign sda_s = sda_sync_q[1];
	assign tick = (div_q == 8'h00);

	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		rd_d = rd_q;
		fast_d = fast_q;
		tx_d = tx_q;
		rx_d = rx_q;
		nack_d = nack_q;
		done_d = done_q;
		frame_d = frame_q;
		idx_d = idx_q;
		phase_d = phase_q;
		scl_d = scl_q;
		sda_d = sda_q;
		div_d = tick ? (fast_q ? 8'(LSC_QTR_FAST - 1) : 8'(LSC_QTR_STD - 1)) : div_q - 8'h01;
		rdata_d = 32'h0;
		if (reg_rd_in) begin
			if (reg_addr_in == LSC_REG_STATUS) begin
				rdata_d = {29'h0, done_q, nack_q, state_q != LSC_M_IDLE && state_q != LSC_M_DONE};
			end else if (reg_addr_in == LSC_REG_RXDATA) begin
				rdata_d = {24'h0, rx_q};
			end else if (reg_addr_in == LSC_REG_TXDATA) begin
				rdata_d = {24'h0, tx_q};
			end else if (reg_addr_in == LSC_REG_CTRL) begin
				rdata_d = {17'h0, addr_q, 5'h0, fast_q, rd_q, 1'b0};
			end
		end
		if (reg_wr_in && reg_addr_in == LSC_REG_TXDATA) begin
			tx_d = reg_wdata_in[7:0];
		end
		case (state_q)
			LSC_M_IDLE, LSC_M_DONE: begin
				if (reg_wr_in && reg_addr_in == LSC_REG_CTRL && reg_wdata_in[LSC_CTRL_GO]) begin
					addr_d = reg_wdata_in[LSC_CTRL_ADDR_LSB +: 7];
					rd_d = reg_wdata_in[LSC_CTRL_READ];
					fast_d = reg_wdata_in[LSC_CTRL_FAST];
					// address msb first, direction, ack slot, byte, ack slot
					frame_d = {reg_wdata_in[LSC_CTRL_ADDR_LSB +: 7], reg_wdata_in[LSC_CTRL_READ],
						1'b1, reg_wdata_in[LSC_CTRL_READ] ? 8'hFF : tx_q, 1'b1};
					nack_d = 1'b0;
					done_d = 1'b0;
					idx_d = 5'h0;
					phase_d = 2'h0;
					sda_d = 1'b0;
					state_d = LSC_M_START;
				end
			end
			LSC_M_START: begin
				if (tick) begin
					scl_d = 1'b0;
					state_d = LSC_M_BIT;
				end
			end
			LSC_M_BIT: begin
				if (tick) begin
					phase_d = phase_q + 2'h1;
					if (phase_q == 2'h0) begin
						sda_d = frame_q[17];
					end else if (phase_q == 2'h1) begin
						scl_d = 1'b1;
					end else if (phase_q == 2'h2) begin
						if (idx_q == 5'd8 && sda_s) begin
							nack_d = 1'b1;
						end
						if (idx_q >= 5'd9 && idx_q <= 5'd16) begin
							rx_d = {rx_q[6:0], sda_s};
						end
					end else begin
						scl_d = 1'b0;
						frame_d = {frame_q[16:0], 1'b1};
						idx_d = idx_q + 5'h1;
						// the single read byte is closed with a nack
						if (idx_q == 5'd17 || (idx_q == 5'd8 && nack_q)) begin
							sda_d = 1'b0;
							state_d = LSC_M_STOP;
						end
					end
				end
			end
			LSC_M_STOP: begin
				if (tick) begin
					if (!scl_q) begin
						scl_d = 1'b1;
					end else begin
						sda_d = 1'b1;
						done_d = 1'b1;
						state_d = LSC_M_DONE;
					end
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			state_q <= LSC_M_IDLE;
			addr_q <= LSC_SLAVE_ADDR;
			rd_q <= 1'b0;
			fast_q <= 1'b0;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			nack_q <= 1'b0;
			done_q <= 1'b0;
			frame_q <= 18'h3FFFF;
			idx_q <= 5'h0;
			phase_q <= 2'h0;
			div_q <= 8'h00;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			rdata_q <= 32'h0;
			sda_sync_q <= LSC_SYNC_RESET;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			fast_q <= fast_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			nack_q <= nack_d;
			done_q <= done_d;
			frame_q <= frame_d;
			idx_q <= idx_d;
			phase_q <= phase_d;
			div_q <= div_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			rdata_q <= rdata_d;
			sda_sync_q <= {sda_sync_q[0], bus.sda};
		end
	end

	assign bus.scl_out_m = 1'b0;
	assign bus.scl_oe_m = !scl_q;
	assign bus.sda_out_m = 1'b0;
	assign bus.sda_oe_m = !sda_q;
	assign reg_rdata_out = rdata_q;
endmodule : lsc_master

// ==== inc/lsc_if.sv ====
// two-wire link between the light sensor and its bus master
interface lsc_if;
	logic scl_out_m;
	logic scl_oe_m;
	logic sda_out_m;
	logic sda_oe_m;
	logic sda_out_s;
	logic sda_oe_s;
	logic scl;
	logic sda;
	// pull-up wired-and: a driver only ever pulls low
	assign scl = !(scl_oe_m && !scl_out_m);
	assign sda = !((sda_oe_m && !sda_out_m) || (sda_oe_s && !sda_out_s));
	modport master (output scl_out_m, output scl_oe_m, output sda_out_m, output sda_oe_m,
		input scl, input sda);
	modport device (output sda_out_s, output sda_oe_s, input scl, input sda);
endinterface : lsc_if

// ==== inc/lsc_pkg.sv ====
// shared constants for the light sensor command port
package lsc_pkg;
	localparam logic [6:0] LSC_SLAVE_ADDR = 7'h39;
	localparam logic [7:0] LSC_CMD_START = 8'h00;
	localparam logic [7:0] LSC_CMD_COMPLETE = 8'h03;
	localparam logic [7:0] LSC_CMD_STAGE_LO = 8'h43;
	localparam logic [7:0] LSC_CMD_STAGE_HI = 8'h83;
	localparam logic [7:0] LSC_CMD_CLR_IT0 = 8'h1D;
	localparam logic [7:0] LSC_CMD_SET_IT1 = 8'h88;
	localparam logic [7:0] LSC_CMD_SET_IT2 = 8'h90;
	localparam logic [7:0] LSC_CMD_IT_DEFAULT = 8'h18;
	localparam logic [2:0] LSC_IT_RESET = 3'h1;
	localparam int LSC_COUNT_W = 16;
	localparam int LSC_CLK_HZ = 25000000;
	localparam int LSC_SCL_HZ_STD = 100000;
	localparam int LSC_SCL_HZ_FAST = 400000;
	// quarter bit period of the master in core cycles
	localparam int LSC_QTR_STD = LSC_CLK_HZ / (4 * LSC_SCL_HZ_STD);
	localparam int LSC_QTR_FAST = LSC_CLK_HZ / (4 * LSC_SCL_HZ_FAST);
	// integration times in microseconds, per selector code
	localparam int LSC_IT_US_000 = 400000;
	localparam int LSC_IT_US_001 = 200000;
	localparam int LSC_IT_US_010 = 100000;
	localparam int LSC_IT_US_011 = 16700;
	localparam int LSC_IT_US_100 = 1000;
	// software port of the master
	localparam logic [1:0] LSC_REG_CTRL = 2'h0;
	localparam logic [1:0] LSC_REG_TXDATA = 2'h1;
	localparam logic [1:0] LSC_REG_STATUS = 2'h2;
	localparam logic [1:0] LSC_REG_RXDATA = 2'h3;
	localparam int LSC_CTRL_GO = 0;
	localparam int LSC_CTRL_READ = 1;
	localparam int LSC_CTRL_FAST = 2;
	localparam int LSC_CTRL_ADDR_LSB = 8;
	localparam int LSC_ST_BUSY = 0;
	localparam int LSC_ST_NACK = 1;
	localparam int LSC_ST_DONE = 2;
	localparam logic [1:0] LSC_SYNC_RESET = 2'h3;
endpackage : lsc_pkg

// ==== test/lsc_assertions.sv ====
// link checker for the light sensor command port
module lsc_assertions
	import lsc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic scl_out_m,
	input wire logic scl_oe_m,
	input wire logic sda_out_m,
	input wire logic sda_oe_m,
	input wire logic sda_out_s,
	input wire logic sda_oe_s,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================================
	// bit tracker: counts scl rises since the last start
	logic scl_q, sda_q, rd_q, rd_d, foreign_q, foreign_d, start_w, stop_w;
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	always_comb begin
		start_w = scl && scl_q && sda_q && !sda;
		stop_w = scl && scl_q && !sda_q && sda;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rd_d = rd_q;
		foreign_d = foreign_q;
		if (start_w) begin
			cnt_d = 5'h00;
			foreign_d = 1'b0;
		end else if (scl && !scl_q) begin
			// saturate so a runaway burst still shows as too many bits
			cnt_d = (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
			sh_d = {sh_q[6:0], sda};
		end else if (cnt_q == 5'h08) begin
			rd_d = sh_q[0];
			foreign_d = (sh_q[7:1] != LSC_SLAVE_ADDR);
		end
	end
	always_ff @(posedge core_clk_in) begin
		scl_q <= reset_n_in ? scl : 1'b1;
		sda_q <= reset_n_in ? sda : 1'b1;
		cnt_q <= reset_n_in ? cnt_d : 5'h00;
		sh_q <= reset_n_in ? sh_d : 8'h00;
		rd_q <= reset_n_in ? rd_d : 1'b0;
		foreign_q <= reset_n_in ? foreign_d : 1'b0;
	end
	// =====================================================================
	// properties
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence ack_s;
		##[1:8] sda_oe_s [*8];
	endsequence
	sequence stop_s;
		##[1:400] stop_w;
	endsequence
	drv_dev_low_a: assert property (sda_oe_s |-> !sda_out_s)
		else $error("device drives sda high");
	drv_mst_low_a: assert property ((scl_oe_m |-> !scl_out_m) and (sda_oe_m |-> !sda_out_m))
		else $error("master drives a line high");
	addr_ack_a: assert property (
		(cnt_q == 5'h08 && sh_q[7:1] == LSC_SLAVE_ADDR && $fell(scl)) |-> ack_s)
		else $error("address not acknowledged");
	wr_ack_a: assert property (
		(cnt_q == 5'h11 && !rd_q && !foreign_q && $fell(scl)) |-> ack_s)
		else $error("write byte not acknowledged");
	foreign_quiet_a: assert property (foreign_q |-> !sda_oe_s)
		else $error("device drives sda for foreign address");
	oe_scl_low_a: assert property ($changed(sda_oe_s) |-> !scl)
		else $error("device sda changes while scl high");
	// eighteen bit clocks plus the stop's own scl rise make nineteen
	one_byte_a: assert property (cnt_q <= 5'h13)
		else $error("more than one data byte in a transfer");
	rd_release_a: assert property ((rd_q && !foreign_q && cnt_q == 5'h12) |-> !sda_oe_s)
		else $error("device holds sda in the master nack slot");
	stop_bound_a: assert property (
		((cnt_q == 5'h12 || foreign_q) && $fell(scl)) |-> stop_s)
		else $error("transfer not closed by stop");
endmodule : lsc_assertions

// ==== test/lsc_bench.sv ====
// self-checking bench: master and device joined over the two-wire link
module lsc_bench
	import lsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CEIL = 60000;
	logic core_clk, reset_n, reg_wr, reg_rd, conv_active, res_valid;
	logic [1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, int_us, st, d;
	logic [15:0] adc_count;
	logic [2:0] it_sel;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	lsc_if link ();
	lsc_master lsc_master_i (.core_clk_in(core_clk), .reset_n_in(reset_n), .bus(link.master),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
	lsc_device lsc_device_i (.core_clk_in(core_clk), .reset_n_in(reset_n), .bus(link.device),
		.adc_count_in(adc_count), .integration_time_select_out(it_sel),
		.conversion_active_out(conv_active), .integration_us_out(int_us),
		.result_valid_out(res_valid));
	lsc_assertions lsc_assertions_i (.core_clk_in(core_clk), .reset_n_in(reset_n),
		.scl_out_m(link.scl_out_m), .scl_oe_m(link.scl_oe_m), .sda_out_m(link.sda_out_m),
		.sda_oe_m(link.sda_oe_m), .sda_out_s(link.sda_out_s), .sda_oe_s(link.sda_oe_s),
		.scl(link.scl), .sda(link.sda));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// =====================================================================
	// shared tasks
	task summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == CEIL) begin
			fails++;
			summarize();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [1:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// one whole transfer; a standard-rate write lasts near 4700 cycles
	task automatic xfer(input logic [6:0] adr, input logic read, input logic fast,
		input logic [7:0] tx);
		int n;
		wr(LSC_REG_TXDATA, {24'h000000, tx});
		wr(LSC_REG_CTRL, {17'h00000, adr, 5'h00, fast, read, 1'b1});
		n = 0;
		st = 32'h00000000;
		while (st[LSC_ST_DONE] !== 1'b1 && n < 3000) begin
			rd(LSC_REG_STATUS, st);
			n++;
		end
		check(32'(n < 3000), 32'h00000001);
	endtask : xfer
	task automatic cmd(input logic [7:0] c, input logic fast);
		xfer(LSC_SLAVE_ADDR, 1'b0, fast, c);
		check(32'(st[LSC_ST_NACK]), 32'h00000000);
	endtask : cmd
	task automatic rd_byte(input logic fast, input logic [7:0] exp);
		xfer(LSC_SLAVE_ADDR, 1'b1, fast, 8'h00);
		rd(LSC_REG_RXDATA, d);
		check({24'h000000, d[7:0]}, {24'h000000, exp});
	endtask : rd_byte
	function automatic logic [31:0] exp_us(input logic [2:0] s);
		case (s)
			3'h0: return LSC_IT_US_000;
			3'h1: return LSC_IT_US_001;
			3'h2: return LSC_IT_US_010;
			3'h3: return LSC_IT_US_011;
			3'h4: return LSC_IT_US_100;
			default: return 32'h00000000;
		endcase
	endfunction : exp_us
	// =====================================================================
	// scenarios
	task automatic t_reset;
		check(32'(it_sel), 32'(LSC_IT_RESET));
		check(int_us, exp_us(3'h1));
		check(32'({conv_active, res_valid}), 32'h00000000);
		rd(LSC_REG_CTRL, d);
		check(d, {17'h00000, LSC_SLAVE_ADDR, 8'h00});
		$display("reset test done");
	endtask : t_reset
	task automatic t_count;
		@(posedge core_clk);
		adc_count <= 16'hA5C3;
		cmd(LSC_CMD_START, 1'b1);
		check(32'({conv_active, res_valid}), 32'h00000002);
		cmd(LSC_CMD_COMPLETE, 1'b0);
		check(32'({conv_active, res_valid}), 32'h00000001);
		@(posedge core_clk);
		adc_count <= 16'h0F0F;
		cmd(LSC_CMD_STAGE_LO, 1'b1);
		rd_byte(1'b0, 8'hC3);
		cmd(LSC_CMD_STAGE_HI, 1'b1);
		rd_byte(1'b1, 8'hA5);
		// a fresh start must drop the valid flag that the completion raised
		cmd(LSC_CMD_START, 1'b1);
		check(32'({conv_active, res_valid}), 32'h00000002);
		$display("count test done");
	endtask : t_count
	task automatic t_select;
		logic [7:0] cmds [10] = '{8'h1D, 8'h88, 8'h90, 8'h18, 8'h88, 8'h55, 8'h18, 8'h1D,
			8'h90, 8'h18};
		logic [2:0] sels [10] = '{3'h0, 3'h2, 3'h6, 3'h1, 3'h3, 3'h3, 3'h1, 3'h0, 3'h4, 3'h1};
		for (int i = 0; i < 10; i++) begin
			cmd(cmds[i], 1'b1);
			check(32'(it_sel), 32'(sels[i]));
			check(int_us, exp_us(sels[i]));
		end
		rd_byte(1'b1, 8'hA5);
		$display("selector test done");
	endtask : t_select
	task automatic t_foreign;
		xfer(7'h3A, 1'b0, 1'b1, LSC_CMD_CLR_IT0);
		check(32'(st[LSC_ST_NACK]), 32'h00000001);
		check(32'(it_sel), 32'(LSC_IT_RESET));
		xfer(7'h38, 1'b1, 1'b1, 8'h00);
		check(32'(st[LSC_ST_NACK]), 32'h00000001);
		$display("foreign address test done");
	endtask : t_foreign
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 32'h00000000;
		adc_count = 16'h0000;
		reset_n = 1'b0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_count();
		t_select();
		t_foreign();
		summarize();
	end
endmodule : lsc_bench
